// ===== design/i2c_bus_mode_controller.sv
// Two-wire bus mode controller with APB register access
//
// Our own choice: the APB register port.
`timescale 1ns/100ps

module i2c_bus_mode_controller #(
  parameter int ADDR_W = 12,
  parameter int CNT_W = 16,
  parameter int HALF_BASE_CYC = i2c_pkg::SCL_HALF_BASE_CYC
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  output logic serial_interrupt
);

  localparam int IDX_W = ADDR_W - 2;

  // Pin synchronisers and edge history
  logic scl_m_r, scl_s_r, scl_q_r;
  logic sda_m_r, sda_s_r, sda_q_r;
  // Registers
  logic [7:0] ctrl1_r, own_r, data_r, rx_sh_r;
  logic mst_r, trx_r, pin_r, bus_busy_r, aas_r, ad0_r, lrb_r;
  logic [1:0] mode_r;
  // Bus engine state
  logic [3:0] bit_cnt_r;
  logic first_r, slave_sel_r, dir_r, hold_r, rs_r, lead_r;
  logic [CNT_W-1:0] low_cnt_r, cnt_r;
  i2c_pkg::master_state_e st_r;
  // APB response, registered line drives and interrupt
  logic ready_r, slverr_r;
  logic [31:0] prdata_r;
  logic scl_oe_r, sda_oe_r, irq_r;

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      scl_m_r <= 1'b1;
      scl_s_r <= 1'b1;
      scl_q_r <= 1'b1;
      sda_m_r <= 1'b1;
      sda_s_r <= 1'b1;
      sda_q_r <= 1'b1;
    end
    else
    begin
      scl_m_r <= scl_i;
      scl_s_r <= scl_m_r;
      scl_q_r <= scl_s_r;
      sda_m_r <= sda_i;
      sda_s_r <= sda_m_r;
      sda_q_r <= sda_s_r;
    end
  end

  logic i2c_on, scl_rise, scl_fall, start_det, stop_det;
  assign i2c_on = mode_r == i2c_pkg::MODE_I2C;
  assign scl_rise = scl_s_r & ~scl_q_r;
  assign scl_fall = ~scl_s_r & scl_q_r;
  assign start_det = i2c_on & scl_s_r & scl_q_r & sda_q_r & ~sda_s_r;
  assign stop_det = i2c_on & scl_s_r & scl_q_r & ~sda_q_r & sda_s_r;

  // APB decode: one wait-free access phase after the setup cycle
  logic [IDX_W-1:0] idx;
  logic apb_setup, apb_done, sel_c1, sel_db, sel_oa, sel_c2, mapped;
  logic wr_c2, data_acc;
  assign idx = paddr[ADDR_W-1:2];
  assign apb_setup = psel & ~penable;
  assign apb_done = psel & penable & ready_r;
  assign sel_c1 = idx == IDX_W'(i2c_pkg::IDX_CONTROL_ONE);
  assign sel_db = idx == IDX_W'(i2c_pkg::IDX_DATA_BUFFER);
  assign sel_oa = idx == IDX_W'(i2c_pkg::IDX_OWN_ADDRESS);
  assign sel_c2 = idx == IDX_W'(i2c_pkg::IDX_CONTROL_TWO);
  assign mapped = sel_c1 | sel_db | sel_oa | sel_c2;
  assign wr_c2 = apb_done & pwrite & sel_c2;
  assign data_acc = apb_done & sel_db & ~slverr_r;

  logic [7:0] status;
  assign status = {mst_r, trx_r, bus_busy_r, pin_r, 1'b0, aas_r, ad0_r, lrb_r};

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ready_r <= 1'b0;
      slverr_r <= 1'b0;
      prdata_r <= 32'h0;
    end
    else if (apb_done)
    begin
      ready_r <= 1'b0;
    end
    else if (apb_setup)
    begin
      ready_r <= 1'b1;
      slverr_r <= ~mapped;
      prdata_r <= 32'h0;
      if (!pwrite && sel_c1)
        prdata_r <= {24'h0, ctrl1_r};
      if (!pwrite && sel_db)
        prdata_r <= {24'h0, data_r};
      if (!pwrite && sel_oa)
        prdata_r <= {24'h0, own_r};
      if (!pwrite && sel_c2)
        prdata_r <= {24'h0, status};
    end
  end

  assign pready = ready_r;
  assign pslverr = ready_r & slverr_r;
  assign prdata = prdata_r;

  // Software requests on control two
  logic wr_mst, wr_trx, wr_bb, start_req, stop_req;
  assign wr_mst = pwdata[i2c_pkg::MST_BIT];
  assign wr_trx = pwdata[i2c_pkg::TRX_BIT];
  assign wr_bb = pwdata[i2c_pkg::BB_BIT];
  assign start_req = wr_c2 & wr_mst & wr_trx & wr_bb & i2c_on
    & (~bus_busy_r | rs_r) & (st_r == i2c_pkg::M_IDLE);
  assign stop_req = wr_c2 & wr_mst & wr_trx & ~wr_bb & bus_busy_r;

  // Word framing
  logic word_done, addr_chk, involved, pin_clr, addr_hit, gen_call;
  logic [7:0] addr_byte;
  logic address_mode_bit;
  assign address_mode_bit = own_r[i2c_pkg::ALS_BIT];
  assign word_done = i2c_on & bus_busy_r & scl_fall & (bit_cnt_r == i2c_pkg::ACK_SLOT);
  assign addr_chk = i2c_on & scl_rise & first_r & (bit_cnt_r == i2c_pkg::LAST_DATA_BIT);
  assign addr_byte = {rx_sh_r[6:0], sda_s_r};
  assign gen_call = addr_byte == 8'h00;
  assign addr_hit = (addr_byte[7:1] == own_r[i2c_pkg::ADDR_MSB:i2c_pkg::ADDR_LSB]) | gen_call;
  assign involved = mst_r | slave_sel_r;
  assign pin_clr = word_done & involved;

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ctrl1_r <= i2c_pkg::CONTROL_ONE_RST;
      own_r <= i2c_pkg::OWN_ADDRESS_RST;
    end
    else if (apb_done && pwrite)
    begin
      if (sel_c1)
        ctrl1_r <= pwdata[7:0];
      if (sel_oa)
        own_r <= pwdata[7:0];
    end
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      data_r <= i2c_pkg::DATA_BUFFER_RST;
    else if (data_acc && pwrite)
      data_r <= pwdata[7:0];
    else if (word_done && involved && !trx_r)
      data_r <= rx_sh_r;
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      mode_r <= i2c_pkg::MODE_PORT;
    else if (wr_c2)
      mode_r <= pwdata[i2c_pkg::MODE_MSB:i2c_pkg::MODE_LSB];
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      mst_r <= 1'b0;
    else if (stop_det)
      mst_r <= 1'b0;
    else if (wr_c2)
      mst_r <= wr_mst;
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      trx_r <= 1'b0;
    else if (stop_det)
      trx_r <= 1'b0;
    else if (word_done && first_r && mst_r)
    begin
      if (!lrb_r)
        trx_r <= ~dir_r;
    end
    else if (word_done && first_r && slave_sel_r && !address_mode_bit)
      trx_r <= dir_r;
    else if (wr_c2)
      trx_r <= wr_trx;
  end

  // Hardware clear wins over a same-cycle software set
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      pin_r <= i2c_pkg::PIN_RST;
    else if (pin_clr)
      pin_r <= 1'b0;
    else if (data_acc || (wr_c2 && pwdata[i2c_pkg::PIN_BIT]))
      pin_r <= 1'b1;
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      bus_busy_r <= 1'b0;
    else if (start_det)
      bus_busy_r <= 1'b1;
    else if (stop_det || !i2c_on)
      bus_busy_r <= 1'b0;
  end

  // Release write while master allows a repeated start on a busy bus
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      rs_r <= 1'b0;
    else if (wr_c2 && mst_r && !wr_mst && !wr_trx && !wr_bb)
      rs_r <= 1'b1;
    else if (start_det || stop_det)
      rs_r <= 1'b0;
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      aas_r <= 1'b0;
    else if (word_done && first_r && !mst_r && slave_sel_r)
      aas_r <= 1'b1;
    else if (data_acc)
      aas_r <= 1'b0;
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      ad0_r <= 1'b0;
    else if (addr_chk && !mst_r && gen_call)
      ad0_r <= 1'b1;
    else if (start_det || stop_det)
      ad0_r <= 1'b0;
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      lrb_r <= 1'b0;
    else if (i2c_on && scl_rise)
      lrb_r <= sda_s_r;
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      bit_cnt_r <= 4'h0;
      first_r <= 1'b0;
      rx_sh_r <= 8'h00;
      dir_r <= 1'b0;
      lead_r <= 1'b0;
    end
    else
    begin
      if (start_det)
      begin
        bit_cnt_r <= 4'h0;
        first_r <= 1'b1;
        lead_r <= 1'b1;
      end
      // The fall that closes a start carries no bit
      else if (i2c_on && scl_fall && lead_r)
        lead_r <= 1'b0;
      else if (i2c_on && scl_fall)
      begin
        bit_cnt_r <= (bit_cnt_r == i2c_pkg::ACK_SLOT) ? 4'h0 : bit_cnt_r + 4'h1;
        if (bit_cnt_r == i2c_pkg::ACK_SLOT)
          first_r <= 1'b0;
      end
      if (i2c_on && scl_rise && bit_cnt_r <= i2c_pkg::LAST_DATA_BIT)
        rx_sh_r <= addr_byte;
      if (addr_chk)
        dir_r <= sda_s_r;
    end
  end

  // Slave selection: address match, or every word when recognition is off
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      slave_sel_r <= 1'b0;
    else if (stop_det || !i2c_on)
      slave_sel_r <= 1'b0;
    else if (start_det)
      slave_sel_r <= address_mode_bit & ~mst_r;
    else if (addr_chk && !mst_r && !address_mode_bit && addr_hit)
      slave_sel_r <= 1'b1;
  end

  logic [CNT_W-1:0] half;
  assign half = CNT_W'(HALF_BASE_CYC) << ctrl1_r[i2c_pkg::RATE_MSB:i2c_pkg::RATE_LSB];

  // SCL hold while service is pending, released one low time after
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      hold_r <= 1'b0;
      low_cnt_r <= '0;
    end
    else if (stop_det || !i2c_on)
    begin
      hold_r <= 1'b0;
      low_cnt_r <= '0;
    end
    else if (pin_clr)
    begin
      hold_r <= 1'b1;
      low_cnt_r <= '0;
    end
    else if (hold_r && pin_r)
    begin
      low_cnt_r <= low_cnt_r + CNT_W'(1);
      if (low_cnt_r >= half - CNT_W'(1))
        hold_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      irq_r <= 1'b0;
    else
      irq_r <= pin_clr;
  end

  // Master clock generator
  logic cnt_done;
  assign cnt_done = cnt_r >= half - CNT_W'(1);

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_r <= i2c_pkg::M_IDLE;
      cnt_r <= '0;
    end
    else if (!i2c_on)
    begin
      st_r <= i2c_pkg::M_IDLE;
      cnt_r <= '0;
    end
    else
    begin
      cnt_r <= cnt_done ? '0 : cnt_r + CNT_W'(1);
      case (st_r)
        i2c_pkg::M_IDLE:
        begin
          cnt_r <= '0;
          if (start_req)
            st_r <= i2c_pkg::M_START;
        end
        i2c_pkg::M_START:
          if (cnt_done)
            st_r <= i2c_pkg::M_LOW;
        i2c_pkg::M_LOW:
          if (cnt_done)
            st_r <= hold_r ? i2c_pkg::M_WAIT : i2c_pkg::M_HIGH;
        i2c_pkg::M_HIGH:
        begin
          // High time counts only once SCL is seen high
          if (!scl_s_r)
            cnt_r <= '0;
          // High phase is half the period, also after a restart
          if (scl_s_r && cnt_done)
            st_r <= i2c_pkg::M_LOW;
        end
        i2c_pkg::M_WAIT:
        begin
          cnt_r <= '0;
          if (stop_req)
            st_r <= i2c_pkg::M_STOP1;
          else if (!mst_r)
            st_r <= i2c_pkg::M_IDLE;
          else if (!hold_r)
            st_r <= i2c_pkg::M_HIGH;
        end
        i2c_pkg::M_STOP1:
          if (cnt_done)
            st_r <= i2c_pkg::M_STOP2;
        i2c_pkg::M_STOP2:
        begin
          if (!scl_s_r)
            cnt_r <= '0;
          if (scl_s_r && cnt_done)
            st_r <= i2c_pkg::M_STOP3;
        end
        i2c_pkg::M_STOP3:
          if (cnt_done)
            st_r <= i2c_pkg::M_IDLE;
        default:
          st_r <= i2c_pkg::M_IDLE;
      endcase
    end
  end

  // Line drive decisions
  logic bit_sda_low, sda_low, scl_low;
  always_comb
  begin
    bit_sda_low = 1'b0;
    if (i2c_on && bus_busy_r && bit_cnt_r <= i2c_pkg::LAST_DATA_BIT)
      bit_sda_low = involved & trx_r & ~data_r[3'd7 - bit_cnt_r[2:0]];
    else if (i2c_on && bus_busy_r)
      bit_sda_low = involved & ctrl1_r[i2c_pkg::ACK_BIT]
        & (~trx_r | (first_r & ~mst_r));
  end

  always_comb
  begin
    case (st_r)
      i2c_pkg::M_START, i2c_pkg::M_STOP1, i2c_pkg::M_STOP2:
        sda_low = 1'b1;
      i2c_pkg::M_STOP3:
        sda_low = 1'b0;
      default:
        sda_low = bit_sda_low;
    endcase
    scl_low = hold_r | (st_r == i2c_pkg::M_LOW) | (st_r == i2c_pkg::M_WAIT)
      | (st_r == i2c_pkg::M_STOP1);
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      scl_oe_r <= 1'b0;
      sda_oe_r <= 1'b0;
    end
    else
    begin
      scl_oe_r <= i2c_on & scl_low;
      sda_oe_r <= i2c_on & sda_low;
    end
  end

  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe = scl_oe_r;
  assign sda_oe = sda_oe_r;
  assign serial_interrupt = irq_r;

endmodule

// ===== design/i2c_pkg.sv
// Constants, register map and encodings of the two-wire bus controller
package i2c_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_CONTROL_ONE = 8'h20;
  localparam logic [7:0] IDX_DATA_BUFFER = 8'h21;
  localparam logic [7:0] IDX_OWN_ADDRESS = 8'h22;
  localparam logic [7:0] IDX_CONTROL_TWO = 8'h23;
  localparam logic [7:0] IDX_STATUS = 8'h23;

  // i2c_control_one fields
  localparam int ACK_BIT = 4;
  localparam int RATE_MSB = 2;
  localparam int RATE_LSB = 0;

  // i2c_control_two and i2c_status fields
  localparam int MST_BIT = 7;
  localparam int TRX_BIT = 6;
  localparam int BB_BIT = 5;
  localparam int PIN_BIT = 4;
  localparam int MODE_MSB = 3;
  localparam int MODE_LSB = 2;
  localparam int AAS_BIT = 2;
  localparam int AD0_BIT = 1;
  localparam int LRB_BIT = 0;

  // own_address_register fields
  localparam int ADDR_MSB = 7;
  localparam int ADDR_LSB = 1;
  localparam int ALS_BIT = 0;

  // Reset values
  localparam logic [7:0] CONTROL_ONE_RST = 8'h00;
  localparam logic [7:0] OWN_ADDRESS_RST = 8'h00;
  localparam logic [7:0] DATA_BUFFER_RST = 8'h00;
  localparam logic PIN_RST = 1'b1;

  typedef enum logic [1:0] {
    MODE_PORT = 2'b00,
    MODE_SIO = 2'b01,
    MODE_I2C = 2'b10,
    MODE_RSVD = 2'b11
  } if_mode_e;

  // Word framing: eight data bits then the acknowledge slot
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;
  localparam logic [3:0] ACK_SLOT = 4'h8;

  // Timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int SCL_HALF_BASE_NS = 2000;
  localparam int SCL_HALF_BASE_CYC = (SCL_HALF_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    M_IDLE = 3'b000,
    M_START = 3'b001,
    M_LOW = 3'b010,
    M_HIGH = 3'b011,
    M_WAIT = 3'b100,
    M_STOP1 = 3'b101,
    M_STOP2 = 3'b110,
    M_STOP3 = 3'b111
  } master_state_e;

endpackage

// ===== tb/i2c_bus_mode_controller_bench.sv
// Self-checking bench for the two-wire bus mode controller
`timescale 1ns/100ps
module i2c_bus_mode_controller_bench;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic scl_oe;
  logic sda_oe;
  logic sda_pull;
  logic serial_interrupt;
  logic scl;
  logic sda;
  logic host_scl_low = 1'b0;
  logic host_sda_low = 1'b0;
  logic ack;
  logic [7:0] rd;
  logic err;
  int mismatches = 0;
  int checked = 0;
  // Address bytes and the status each leaves: acked write, no ack, acked read
  logic [7:0] addrs [3] = '{8'ha4, 8'h30, 8'ha5};
  logic [7:0] stat [3] = '{8'he0, 8'he1, 8'ha0};
  assign scl = !(scl_oe || host_scl_low);
  assign sda = !(sda_oe || sda_pull || host_sda_low);
  always #4 core_clk = ~core_clk;
  i2c_bus_mode_controller #(
    .HALF_BASE_CYC(8)
  ) DUT (
    .core_clk(core_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .scl_i(scl), .scl_o(), .scl_oe(scl_oe), .sda_i(sda), .sda_o(), .sda_oe(sda_oe),
    .serial_interrupt(serial_interrupt)
  );
  i2c_peer #(
    .PEER_ADDR(7'h52)
  ) peer (
    .scl(scl),
    .sda(sda),
    .sda_pull(sda_pull)
  );
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h000000, wd};
    @(posedge core_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge core_clk);
    end
    while (pready !== 1'b1);
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp, input string nm);
    apb(1'b0, idx, 8'h00);
    chk(nm, rd, exp);
  endtask
  task automatic wait_irq();
    int n;
    n = 0;
    while (serial_interrupt !== 1'b1 && n < 1000)
    begin
      @(posedge core_clk);
      n++;
    end
    chk("interrupt", {7'h00, serial_interrupt}, 8'h01);
  endtask
  // Bench as bus master: one bit, SDA set a cycle after SCL falls
  task automatic host_bit(input logic b, output logic seen);
    @(posedge core_clk);
    host_sda_low <= !b;
    repeat (8) @(posedge core_clk);
    host_scl_low <= 1'b0;
    do
    begin
      @(posedge core_clk);
    end
    while (scl !== 1'b1);
    repeat (8) @(posedge core_clk);
    seen = sda;
    host_scl_low <= 1'b1;
  endtask
  // Start, eight bits, then the acknowledge slot; ends on the ninth fall
  task automatic host_word(input logic [7:0] b, output logic seen);
    logic x;
    host_sda_low <= 1'b1;
    repeat (8) @(posedge core_clk);
    host_scl_low <= 1'b1;
    for (int k = 7; k >= 0; k--)
      host_bit(b[k], x);
    host_bit(1'b1, seen);
  endtask
  task automatic host_stop();
    @(posedge core_clk);
    host_sda_low <= 1'b1;
    repeat (8) @(posedge core_clk);
    host_scl_low <= 1'b0;
    do
    begin
      @(posedge core_clk);
    end
    while (scl !== 1'b1);
    repeat (8) @(posedge core_clk);
    host_sda_low <= 1'b0;
    repeat (8) @(posedge core_clk);
  endtask
  task automatic wrap_up();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge core_clk);
    mismatches++;
    wrap_up();
  end
  initial
  begin
    int n;
    repeat (10) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    rdchk(i2c_pkg::IDX_STATUS, 8'h10, "status reset");
    rdchk(i2c_pkg::IDX_OWN_ADDRESS, 8'h00, "own_address reset");
    apb(1'b0, 8'h30, 8'h00);
    chk("unmapped", {7'h00, err}, 8'h01);
    apb(1'b1, i2c_pkg::IDX_OWN_ADDRESS, 8'h66);
    rdchk(i2c_pkg::IDX_OWN_ADDRESS, 8'h66, "own_address");
    apb(1'b1, i2c_pkg::IDX_CONTROL_ONE, 8'h10);
    rdchk(i2c_pkg::IDX_CONTROL_ONE, 8'h10, "control_one");
    apb(1'b1, i2c_pkg::IDX_CONTROL_TWO, 8'h08);
    rdchk(i2c_pkg::IDX_STATUS, 8'h10, "pending kept");
    // Start requests in the other modes, bus free throughout
    for (int m = 0; m < 4; m++)
      if (m != 2)
      begin
        apb(1'b1, i2c_pkg::IDX_CONTROL_TWO, 8'hf0 | 8'(m << 2));
        repeat (30) @(posedge core_clk);
        chk("lines", {6'h00, sda_oe, scl_oe}, 8'h00);
      end
    apb(1'b1, i2c_pkg::IDX_CONTROL_TWO, 8'h18);
    for (int i = 0; i < 3; i++)
    begin
      apb(1'b1, i2c_pkg::IDX_DATA_BUFFER, addrs[i]);
      apb(1'b1, i2c_pkg::IDX_CONTROL_TWO, 8'hf8);
      wait_irq();
      chk("address byte", peer.sh, addrs[i]);
      chk("clock held", {7'h00, scl_oe}, 8'h01);
      rdchk(i2c_pkg::IDX_STATUS, stat[i], "status address");
      if (i == 0)
      begin
        apb(1'b1, i2c_pkg::IDX_DATA_BUFFER, 8'h3c);
        wait_irq();
        chk("data byte", peer.sh, 8'h3c);
        rdchk(i2c_pkg::IDX_STATUS, 8'he0, "status data");
      end
      apb(1'b1, i2c_pkg::IDX_CONTROL_TWO, 8'hd8);
      n = 0;
      do
      begin
        apb(1'b0, i2c_pkg::IDX_STATUS, 8'h00);
        n++;
      end
      while (rd !== 8'h10 && n < 40);
      chk("status stop", rd, 8'h10);
      chk("lines idle", {6'h00, scl, sda}, 8'h03);
    end
    // Slave side: own address, then a general call, each closed by the bench
    for (int g = 0; g < 2; g++)
    begin
      host_word(g ? 8'h00 : 8'h66, ack);
      chk("slave ack", {7'h00, ack}, 8'h00);
      wait_irq();
      rdchk(i2c_pkg::IDX_STATUS, g ? 8'h26 : 8'h24, "status slave");
      rdchk(i2c_pkg::IDX_DATA_BUFFER, g ? 8'h00 : 8'h66, "slave data");
      rdchk(i2c_pkg::IDX_STATUS, g ? 8'h32 : 8'h30, "status served");
      host_stop();
      rdchk(i2c_pkg::IDX_STATUS, 8'h10, "status slave stop");
    end
    wrap_up();
  end
endmodule

// ===== tb/i2c_bus_mode_controller_monitor.sv
// Port checker for the two-wire bus mode controller
`timescale 1ns/100ps
module i2c_bus_mode_controller_monitor #(
  parameter int ADDR_W = 12,
  parameter int HALF_BASE_CYC = 8
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic scl_i,
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic serial_interrupt
);
  localparam int REL_MAX = 2 * HALF_BASE_CYC + 8;
  localparam int STOP_MAX = 4 * HALF_BASE_CYC + 8;
  logic [15:0] low_cnt;
  logic [15:0] high_cnt;
  logic [3:0] rise_cnt;
  logic scl_q;
  logic sda_q;
  logic acc;
  logic ctl;
  logic [ADDR_W-3:0] idx;
  assign acc = psel && penable && pready;
  assign idx = paddr[ADDR_W-1:2];
  assign ctl = acc && pwrite && idx == i2c_pkg::IDX_CONTROL_TWO;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);
  // Length of SCL drive, of SCL high, and clock rises since start or word end
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      low_cnt <= '0;
      high_cnt <= '0;
      rise_cnt <= '0;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end
    else
    begin
      low_cnt <= scl_oe ? low_cnt + 16'h1 : 16'h0;
      high_cnt <= (scl_i && !scl_oe) ? high_cnt + 16'h1 : 16'h0;
      scl_q <= scl_i;
      sda_q <= sda_i;
      if (serial_interrupt || (scl_i && scl_q && sda_q && !sda_i))
        rise_cnt <= 4'h0;
      else if (scl_i && !scl_q)
        rise_cnt <= rise_cnt + 4'h1;
    end
  end
  property p_ready_first;
    psel && !penable ##1 psel && penable |-> pready;
  endproperty
  a_ready_first: assert property (p_ready_first) else $error("pready late");
  property p_err_map;
    acc |-> pslverr == (idx[ADDR_W-3:2] != 8'h08);
  endproperty
  a_err_map: assert property (p_err_map) else $error("pslverr wrong");
  property p_scl_low;
    $fell(scl_oe) |-> low_cnt >= HALF_BASE_CYC;
  endproperty
  a_scl_low: assert property (p_scl_low) else $error("scl low too short");
  property p_scl_high;
    $rose(scl_oe) && $past(scl_i) |-> high_cnt >= HALF_BASE_CYC;
  endproperty
  a_scl_high: assert property (p_scl_high) else $error("scl high too short");
  property p_start;
    ctl && pwdata[7:5] == 3'b111 && pwdata[3:2] == 2'b10 && !scl_oe && !sda_oe
      |-> ##[1:3] (sda_oe && !scl_oe);
  endproperty
  a_start: assert property (p_start) else $error("no start");
  property p_stop;
    ctl && pwdata[7:4] == 4'b1101 && scl_oe
      |-> ##[1:STOP_MAX] ($fell(sda_oe) && !scl_oe && scl_i);
  endproperty
  a_stop: assert property (p_stop) else $error("no stop");
  property p_hold;
    serial_interrupt |-> ##[0:2] scl_oe ##1 scl_oe [*3];
  endproperty
  a_hold: assert property (p_hold) else $error("scl not held");
  property p_irq_pulse;
    serial_interrupt |=> !serial_interrupt;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("irq too long");
  property p_release;
    acc && idx == i2c_pkg::IDX_DATA_BUFFER && scl_oe |=> scl_oe [*4] ##[1:REL_MAX] !scl_oe;
  endproperty
  a_release: assert property (p_release) else $error("scl release wrong");
  property p_word;
    serial_interrupt |-> rise_cnt == 4'h9;
  endproperty
  a_word: assert property (p_word) else $error("word not nine clocks");
endmodule

bind i2c_bus_mode_controller i2c_bus_mode_controller_monitor #(
  .ADDR_W(ADDR_W),
  .HALF_BASE_CYC(HALF_BASE_CYC)
) mon (
  .core_clk(core_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .scl_i(scl_i), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_i), .sda_o(sda_o),
  .sda_oe(sda_oe), .serial_interrupt(serial_interrupt)
);

// ===== tb/i2c_peer.sv
// Far-side slave that acknowledges its own address and written bytes
`timescale 1ns/100ps
module i2c_peer #(
  parameter logic [6:0] PEER_ADDR = 7'h52
) (
  input wire logic scl,
  input wire logic sda,
  output logic sda_pull
);
  logic [7:0] sh = 8'h00;
  logic first = 1'b0;
  int cnt = 0;
  initial sda_pull = 1'b0;
  always @(negedge sda)
    if (scl)
    begin
      cnt = 0;
      first = 1'b1;
    end
  always @(posedge sda)
    if (scl)
      cnt = 0;
  always @(posedge scl)
    if (cnt < 8)
    begin
      sh = {sh[6:0], sda};
      cnt = cnt + 1;
    end
  // Acts only as a slave; pulls SDA for the ninth clock, then releases
  always @(negedge scl)
    if (cnt == 8)
    begin
      sda_pull = !first || sh[7:1] == PEER_ADDR;
      cnt = 9;
    end
    else if (cnt == 9)
    begin
      sda_pull = 1'b0;
      cnt = 0;
      first = 1'b0;
    end
endmodule
